/* rtl/lpa_pkg.sv */
package lpa_pkg;
  localparam int WORD_W = 20;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 7;
  localparam int SEL_W = 3;
  localparam int SWING_W = 4;
  localparam int CNT_W = 8;
  localparam int FRAME_BITS = 24;
  localparam int HDR_BITS = 8;
  localparam logic [4:0] HDR_LAST = 5'h07;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam logic OP_READ = 1'b1;
  localparam logic OP_WRITE = 1'b0;

  localparam int CLK_PERIOD_NS = 8;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // device map, reached over the link
  localparam logic [ADDR_W-1:0] ADDR_ALARM = 7'h06;
  localparam logic [ADDR_W-1:0] ADDR_LOOP = 7'h07;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 7'h20;
  localparam logic [ADDR_W-1:0] ADDR_SWING = 7'h21;
  localparam logic [DATA_W-1:0] RST_ALARM = 16'h0000;
  localparam logic [DATA_W-1:0] RST_LOOP = 16'h0700;
  localparam logic [DATA_W-1:0] MASK_ALARM = 16'h0778;
  localparam logic [DATA_W-1:0] MASK_LOOP = 16'h37FF;
  localparam logic [SWING_W-1:0] SWING_ZERO = 4'h0;

  // alarm_replace_control fields
  localparam int B_SIG_ROUTE = 10;
  localparam int B_SYNC_ROUTE = 9;
  localparam int B_PLL_ROUTE = 8;
  localparam int B_REP_SIG = 6;
  localparam int B_REP_SYNC = 5;
  localparam int B_REP_PLL = 4;
  localparam int B_BAD_ROUTE = 3;
  // loopback_pattern_control fields
  localparam int B_GEN = 13;
  localparam int B_CHK = 12;
  localparam int B_SEL_LO = 8;
  localparam int B_GAIN_ROUTE = 7;
  localparam int B_CAL_ROUTE = 6;
  localparam int B_REP_GAIN = 5;
  localparam int B_REP_CAL = 4;
  localparam int B_FAR_FULL = 3;
  localparam int B_FAR_CODEC = 2;
  localparam int B_NEAR_SER = 1;
  localparam int B_NEAR_ENC = 0;
  // device status fields
  localparam int ST_CAL = 0;
  localparam int ST_GAIN = 1;
  localparam int ST_CHK_ERR = 2;
  localparam int ST_CNT_LO = 8;

  localparam logic [SEL_W-1:0] PAT_CRPAT_LONG = 3'h3;
  localparam logic [SEL_W-1:0] PAT_CRPAT_SHORT = 3'h4;
  localparam logic [SEL_W-1:0] PAT_PRBS7 = 3'h5;
  localparam logic [SEL_W-1:0] PAT_PRBS23 = 3'h6;
  localparam logic [SEL_W-1:0] PAT_PRBS31 = 3'h7;
  localparam int PRBS7_TAP_A = 7;
  localparam int PRBS7_TAP_B = 6;
  localparam int PRBS23_TAP_A = 23;
  localparam int PRBS23_TAP_B = 18;
  localparam int PRBS31_TAP_A = 31;
  localparam int PRBS31_TAP_B = 28;
  localparam logic [30:0] PRBS_SEED = 31'h7FFFFFFF;

  // two decoded lanes, each {pad, k flag, byte}
  localparam logic [WORD_W-1:0] K307_WORD = 20'h7F9FE;
  localparam logic [WORD_W-1:0] ZERO_WORD = 20'h00000;
  localparam logic [WORD_W-1:0] CRPAT_TABLE [4] = '{20'h17C83, 20'hAAAAA, 20'hF83E0, 20'h55555};
  localparam logic [1:0] CRPAT_SHORT_LAST = 2'h1;

  // host controller registers
  localparam logic [ADDR_W-1:0] H_TARGET = 7'h00;
  localparam logic [ADDR_W-1:0] H_WDATA = 7'h01;
  localparam logic [ADDR_W-1:0] H_GO = 7'h02;
  localparam logic [ADDR_W-1:0] H_STAT = 7'h03;
  localparam logic [ADDR_W-1:0] H_RDATA = 7'h04;
  localparam int HS_BUSY = 0;
  localparam int HS_REFUSED = 1;
  localparam int HS_GAIN_VALID = 2;
endpackage

/* rtl/lpa_link_if.sv */
`timescale 1ns/10ps
interface lpa_link_if;
  logic link_clk;
  logic link_sel;
  logic link_mosi;
  logic link_miso;
  modport host (output link_clk, output link_sel, output link_mosi, input link_miso);
  modport dev (input link_clk, input link_sel, input link_mosi, output link_miso);
endinterface

/* rtl/lpa_host.sv */
`timescale 1ns/10ps
module lpa_host import lpa_pkg::*; (
  input wire logic ref_clk,
  input wire logic srst,
  lpa_link_if.host link,
  input wire logic [ADDR_W-1:0] sw_addr,
  input wire logic [DATA_W-1:0] sw_wdata,
  input wire logic sw_write,
  input wire logic sw_read,
  output logic [DATA_W-1:0] sw_rdata,
  input wire logic full_rate
);
  typedef enum logic [1:0] {HC_IDLE, HC_STAT, HC_SWING, HC_MAIN} lpa_hstate_type;
  lpa_hstate_type state_reg;
  logic [ADDR_W-1:0] target_reg;
  logic [DATA_W-1:0] wdata_reg, rdata_reg;
  logic op_reg, refused_reg, near_ser_shadow_reg;
  logic start_reg, done_reg;
  logic [FRAME_BITS-1:0] frame_reg;
  logic [1:0] miso_sync_reg;
  logic [5:0] half_cnt_reg;
  logic [4:0] bit_cnt_reg;
  logic busy_reg, clk_reg, sel_reg, mosi_reg;
  logic [FRAME_BITS-1:0] tx_shift_reg;
  logic [DATA_W-1:0] rx_shift_reg;
  logic tick, go, crpat_req, bad_rate;

  assign link.link_clk = clk_reg;
  assign link.link_sel = sel_reg;
  assign link.link_mosi = mosi_reg;
  assign tick = busy_reg && (half_cnt_reg == 6'(LINK_HALF_CYC - 1));
  assign go = sw_write && (sw_addr == H_GO) && (state_reg == HC_IDLE);
  assign crpat_req = (wdata_reg[B_SEL_LO +: SEL_W] == PAT_CRPAT_LONG) ||
                     (wdata_reg[B_SEL_LO +: SEL_W] == PAT_CRPAT_SHORT);
  assign bad_rate = full_rate && crpat_req && (wdata_reg[B_GEN] || wdata_reg[B_CHK]);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      miso_sync_reg <= 2'h0;
    end else begin
      miso_sync_reg <= {miso_sync_reg[0], link.link_miso};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      target_reg <= 7'h00;
      wdata_reg <= 16'h0000;
    end else if (sw_write && state_reg == HC_IDLE) begin
      if (sw_addr == H_TARGET) target_reg <= sw_wdata[ADDR_W-1:0];
      if (sw_addr == H_WDATA) wdata_reg <= sw_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sw_rdata <= 16'h0000;
    end else if (sw_read) begin
      case (sw_addr)
        H_TARGET: sw_rdata <= {9'h000, target_reg};
        H_WDATA: sw_rdata <= wdata_reg;
        H_STAT: sw_rdata <= {13'h0000, !near_ser_shadow_reg, refused_reg, state_reg != HC_IDLE};
        H_RDATA: sw_rdata <= rdata_reg;
        default: sw_rdata <= 16'h0000;
      endcase
    end else begin
      sw_rdata <= 16'h0000;
    end
  end

  // order sequencer: guards loopback writes before they reach the device
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= HC_IDLE;
      op_reg <= OP_WRITE;
      refused_reg <= 1'b0;
      near_ser_shadow_reg <= 1'b0;
      start_reg <= 1'b0;
      frame_reg <= '0;
      rdata_reg <= 16'h0000;
    end else begin
      start_reg <= 1'b0;
      case (state_reg)
        HC_IDLE: begin
          if (go) begin
            op_reg <= sw_wdata[0];
            refused_reg <= 1'b0;
            if (sw_wdata[0] == OP_WRITE && target_reg == ADDR_LOOP && bad_rate) begin
              refused_reg <= 1'b1;
            end else if (sw_wdata[0] == OP_WRITE && target_reg == ADDR_LOOP &&
                         wdata_reg[B_NEAR_SER]) begin
              frame_reg <= {OP_READ, ADDR_STATUS, 16'h0000};
              start_reg <= 1'b1;
              state_reg <= HC_STAT;
            end else begin
              frame_reg <= {sw_wdata[0], target_reg, wdata_reg};
              start_reg <= 1'b1;
              state_reg <= HC_MAIN;
            end
          end
        end
        HC_STAT: begin
          if (done_reg) begin
            if (rx_shift_reg[ST_CAL]) begin
              frame_reg <= {OP_WRITE, ADDR_SWING, 12'h000, SWING_ZERO};
              start_reg <= 1'b1;
              state_reg <= HC_SWING;
            end else begin
              refused_reg <= 1'b1;
              state_reg <= HC_IDLE;
            end
          end
        end
        HC_SWING: begin
          if (done_reg) begin
            frame_reg <= {OP_WRITE, target_reg, wdata_reg};
            start_reg <= 1'b1;
            state_reg <= HC_MAIN;
          end
        end
        HC_MAIN: begin
          if (done_reg) begin
            if (op_reg == OP_READ) rdata_reg <= rx_shift_reg;
            // gain lock status is not trusted while the serializer loop runs
            if (op_reg == OP_WRITE && target_reg == ADDR_LOOP) begin
              near_ser_shadow_reg <= wdata_reg[B_NEAR_SER];
            end
            state_reg <= HC_IDLE;
          end
        end
        default: state_reg <= HC_IDLE;
      endcase
    end
  end

  // frame engine: link clock made by dividing ref_clk, bits change while it is low
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy_reg <= 1'b0;
      clk_reg <= 1'b0;
      sel_reg <= 1'b0;
      mosi_reg <= 1'b0;
      half_cnt_reg <= 6'h00;
      bit_cnt_reg <= 5'h00;
      tx_shift_reg <= '0;
      rx_shift_reg <= 16'h0000;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start_reg) begin
        busy_reg <= 1'b1;
        sel_reg <= 1'b1;
        mosi_reg <= frame_reg[FRAME_BITS-1];
        tx_shift_reg <= {frame_reg[FRAME_BITS-2:0], 1'b0};
        half_cnt_reg <= 6'h00;
        bit_cnt_reg <= 5'h00;
      end else if (busy_reg) begin
        half_cnt_reg <= tick ? 6'h00 : half_cnt_reg + 6'h01;
        if (tick) begin
          clk_reg <= !clk_reg;
          if (!clk_reg) begin
            rx_shift_reg <= {rx_shift_reg[DATA_W-2:0], miso_sync_reg[1]};
          end else if (bit_cnt_reg == FRAME_LAST) begin
            busy_reg <= 1'b0;
            sel_reg <= 1'b0;
            mosi_reg <= 1'b0;
            done_reg <= 1'b1;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            mosi_reg <= tx_shift_reg[FRAME_BITS-1];
            tx_shift_reg <= {tx_shift_reg[FRAME_BITS-2:0], 1'b0};
          end
        end
      end
    end
  end
endmodule // lpa_host

/* rtl/lpa_device.sv */
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
module lpa_device import lpa_pkg::*; #(
  parameter logic [SWING_W-1:0] SWING_RESET = 4'h8
) (
  input wire logic ref_clk,
  input wire logic srst,
  lpa_link_if.dev link,
  input wire logic [WORD_W-1:0] rx_raw_word,
  input wire logic [WORD_W-1:0] rx_decoded_word,
  input wire logic decoder_enable,
  input wire logic [WORD_W-1:0] tx_par_word,
  input wire logic [WORD_W-1:0] tx_encoded_word,
  input wire logic signal_lost,
  input wire logic sync_lost,
  input wire logic pll_locked,
  input wire logic gain_loop_locked,
  input wire logic offset_cal_complete,
  input wire logic bad_symbol,
  output logic [WORD_W-1:0] rx_par_word,
  output logic [WORD_W-1:0] encoder_in_word,
  output logic [WORD_W-1:0] serializer_word,
  output logic serial_out_enable,
  output logic [SWING_W-1:0] tx_swing,
  output logic channel_alarm_pin
);
  logic [2:0] lclk_sync_reg;
  logic [1:0] sel_sync_reg, mosi_sync_reg;
  logic [4:0] bit_cnt_reg;
  logic [FRAME_BITS-2:0] shift_in_reg;
  logic [DATA_W-1:0] rd_shift_reg;
  logic [DATA_W-1:0] alarm_ctrl_reg, loop_ctrl_reg, rd_value;
  logic [WORD_W-1:0] near_ser_pipe_reg;
  logic [30:0] gen_state_reg, chk_state_reg;
  logic [1:0] gen_idx_reg, chk_idx_reg;
  logic [CNT_W-1:0] err_cnt_reg;
  logic chk_err_reg;
  logic rise, mosi_s, wr_hit, rd_hit;
  logic [ADDR_W-1:0] rd_addr;
  logic [SEL_W-1:0] pat_sel;
  logic gain_ok, gain_bad, replace;
  logic [WORD_W-1:0] rx_src, pat_word;
  logic [WORD_W+30:0] gen_step, chk_step;
  logic is_crpat, is_prbs;
  logic [1:0] gen_last;

  assign link.link_miso = rd_shift_reg[DATA_W-1];
  assign rise = lclk_sync_reg[1] && !lclk_sync_reg[2];
  assign mosi_s = mosi_sync_reg[1];
  assign rd_hit = rise && sel_sync_reg[1] && bit_cnt_reg == HDR_LAST &&
                  shift_in_reg[ADDR_W-1] == OP_READ;
  assign rd_addr = {shift_in_reg[ADDR_W-2:0], mosi_s};
  assign wr_hit = rise && sel_sync_reg[1] && bit_cnt_reg == FRAME_LAST &&
                  shift_in_reg[FRAME_BITS-2] == OP_WRITE;
  assign pat_sel = loop_ctrl_reg[B_SEL_LO +: SEL_W];
  assign is_crpat = (pat_sel == PAT_CRPAT_LONG) || (pat_sel == PAT_CRPAT_SHORT);
  assign is_prbs = (pat_sel == PAT_PRBS7) || (pat_sel == PAT_PRBS23) || (pat_sel == PAT_PRBS31);
  assign gen_last = (pat_sel == PAT_CRPAT_SHORT) ? CRPAT_SHORT_LAST : 2'h3;
  // lock indication is meaningless while the serializer loop is closed
  assign gain_ok = gain_loop_locked || loop_ctrl_reg[B_NEAR_SER];
  assign gain_bad = !gain_ok;

  // shifts 20 bits through the selected lfsr; with use_word the received bits
  // are shifted in instead, so the checker locks to any phase of the sequence
  function automatic logic [WORD_W+30:0] prbs_walk(input logic [30:0] st,
                                                   input logic [SEL_W-1:0] sel,
                                                   input logic [WORD_W-1:0] word,
                                                   input logic use_word);
    logic [30:0] s;
    logic [WORD_W-1:0] o;
    logic nb;
    s = st;
    o = '0;
    nb = 1'b0;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      case (sel)
        PAT_PRBS7: nb = s[PRBS7_TAP_A-1] ^ s[PRBS7_TAP_B-1];
        PAT_PRBS23: nb = s[PRBS23_TAP_A-1] ^ s[PRBS23_TAP_B-1];
        default: nb = s[PRBS31_TAP_A-1] ^ s[PRBS31_TAP_B-1];
      endcase
      o[i] = nb;
      s = {s[29:0], use_word ? word[i] : nb};
    end
    return {o, s};
  endfunction

  assign gen_step = prbs_walk(gen_state_reg, pat_sel, ZERO_WORD, 1'b0);
  assign chk_step = prbs_walk(chk_state_reg, pat_sel, rx_raw_word, 1'b1);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lclk_sync_reg <= 3'h0;
      sel_sync_reg <= 2'h0;
      mosi_sync_reg <= 2'h0;
    end else begin
      lclk_sync_reg <= {lclk_sync_reg[1:0], link.link_clk};
      sel_sync_reg <= {sel_sync_reg[0], link.link_sel};
      mosi_sync_reg <= {mosi_sync_reg[0], link.link_mosi};
    end
  end

  // frame: op bit, address, data; bits taken on link clock rising edges
  always_ff @(posedge ref_clk) begin
    if (srst || !sel_sync_reg[1]) begin
      bit_cnt_reg <= 5'h00;
      shift_in_reg <= '0;
    end else if (rise) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      shift_in_reg <= {shift_in_reg[FRAME_BITS-3:0], mosi_s};
    end
  end

  always_comb begin
    case (rd_addr)
      ADDR_ALARM: rd_value = alarm_ctrl_reg;
      ADDR_LOOP: rd_value = loop_ctrl_reg;
      ADDR_STATUS: rd_value = {err_cnt_reg, 5'h00, chk_err_reg, gain_ok, offset_cal_complete};
      ADDR_SWING: rd_value = {12'h000, tx_swing};
      default: rd_value = 16'h0000;
    endcase
  end

  // read data goes out msb first; host samples it on the following rising edges
  always_ff @(posedge ref_clk) begin
    if (srst || !sel_sync_reg[1]) begin
      rd_shift_reg <= 16'h0000;
    end else if (rd_hit) begin
      rd_shift_reg <= rd_value;
    end else if (rise && bit_cnt_reg > HDR_LAST) begin
      rd_shift_reg <= {rd_shift_reg[DATA_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      alarm_ctrl_reg <= RST_ALARM;
    end else if (wr_hit && shift_in_reg[FRAME_BITS-3 -: ADDR_W] == ADDR_ALARM) begin
      alarm_ctrl_reg <= {shift_in_reg[DATA_W-2:0], mosi_s} & MASK_ALARM;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      loop_ctrl_reg <= RST_LOOP;
    end else if (wr_hit && shift_in_reg[FRAME_BITS-3 -: ADDR_W] == ADDR_LOOP) begin
      loop_ctrl_reg <= {shift_in_reg[DATA_W-2:0], mosi_s} & MASK_LOOP;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_swing <= SWING_RESET;
    end else if (wr_hit && shift_in_reg[FRAME_BITS-3 -: ADDR_W] == ADDR_SWING) begin
      tx_swing <= {shift_in_reg[SWING_W-2:0], mosi_s};
    end
  end

  // receive side: loop source, then fault replacement
  always_comb begin
    if (loop_ctrl_reg[B_NEAR_SER]) begin
      rx_src = near_ser_pipe_reg;
    end else if (loop_ctrl_reg[B_NEAR_ENC]) begin
      rx_src = tx_encoded_word;
    end else begin
      rx_src = rx_decoded_word;
    end
  end

  assign replace = (alarm_ctrl_reg[B_REP_SIG] && signal_lost) ||
                   (alarm_ctrl_reg[B_REP_SYNC] && sync_lost) ||
                   (alarm_ctrl_reg[B_REP_PLL] && !pll_locked) ||
                   (loop_ctrl_reg[B_REP_GAIN] && gain_bad) ||
                   (loop_ctrl_reg[B_REP_CAL] && !offset_cal_complete);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      near_ser_pipe_reg <= ZERO_WORD;
      rx_par_word <= ZERO_WORD;
    end else begin
      // the serializer loop passes an extra deserializer stage
      near_ser_pipe_reg <= tx_encoded_word;
      rx_par_word <= replace ? (decoder_enable ? K307_WORD : ZERO_WORD) : rx_src;
    end
  end

  // transmit side
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      encoder_in_word <= ZERO_WORD;
      serializer_word <= ZERO_WORD;
      serial_out_enable <= 1'b1;
    end else begin
      if (loop_ctrl_reg[B_FAR_FULL]) begin
        encoder_in_word <= rx_par_word;
      end else if (loop_ctrl_reg[B_FAR_CODEC]) begin
        encoder_in_word <= rx_decoded_word;
      end else begin
        encoder_in_word <= tx_par_word;
      end
      serializer_word <= loop_ctrl_reg[B_GEN] ? pat_word : tx_encoded_word;
      serial_out_enable <= !loop_ctrl_reg[B_NEAR_SER];
    end
  end

  // reserved selector codes send an all-zero word
  always_comb begin
    if (is_crpat) begin
      pat_word = CRPAT_TABLE[gen_idx_reg];
    end else if (is_prbs) begin
      pat_word = gen_step[WORD_W+30:31];
    end else begin
      pat_word = ZERO_WORD;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || !loop_ctrl_reg[B_GEN]) begin
      gen_state_reg <= PRBS_SEED;
      gen_idx_reg <= 2'h0;
    end else begin
      gen_state_reg <= gen_step[30:0];
      gen_idx_reg <= (gen_idx_reg == gen_last) ? 2'h0 : gen_idx_reg + 2'h1;
    end
  end

  // checker: prbs is self-aligning, crpat realigns on the first table word
  always_ff @(posedge ref_clk) begin
    if (srst || !loop_ctrl_reg[B_CHK]) begin
      chk_state_reg <= PRBS_SEED;
      chk_idx_reg <= 2'h0;
      chk_err_reg <= 1'b0;
      err_cnt_reg <= 8'h00;
    end else begin
      chk_state_reg <= chk_step[30:0];
      if (is_crpat) begin
        chk_idx_reg <= (rx_raw_word == CRPAT_TABLE[0]) ? 2'h1 :
                       (chk_idx_reg == gen_last) ? 2'h0 : chk_idx_reg + 2'h1;
        chk_err_reg <= rx_raw_word != CRPAT_TABLE[chk_idx_reg];
      end else begin
        chk_err_reg <= is_prbs && (chk_step[WORD_W+30:31] != rx_raw_word);
      end
      if (chk_err_reg && err_cnt_reg != 8'hFF) begin
        err_cnt_reg <= err_cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      channel_alarm_pin <= 1'b0;
    end else begin
      channel_alarm_pin <= (alarm_ctrl_reg[B_BAD_ROUTE] && bad_symbol) ||
                           (loop_ctrl_reg[B_GAIN_ROUTE] && gain_bad) ||
                           (loop_ctrl_reg[B_CAL_ROUTE] && !offset_cal_complete) ||
                           (alarm_ctrl_reg[B_SIG_ROUTE] && signal_lost) ||
                           (alarm_ctrl_reg[B_SYNC_ROUTE] && sync_lost) ||
                           (alarm_ctrl_reg[B_PLL_ROUTE] && !pll_locked);
    end
  end
endmodule // lpa_device

/* bench/lpa_checker.sv */
`timescale 1ns/10ps
module lpa_checker import lpa_pkg::*; (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic link_sel,
  input wire logic link_mosi,
  input wire logic [WORD_W-1:0] rx_decoded_word,
  input wire logic [WORD_W-1:0] tx_encoded_word,
  input wire logic decoder_enable,
  input wire logic signal_lost,
  input wire logic sync_lost,
  input wire logic pll_locked,
  input wire logic gain_loop_locked,
  input wire logic offset_cal_complete,
  input wire logic bad_symbol,
  input wire logic [WORD_W-1:0] rx_par_word,
  input wire logic [WORD_W-1:0] encoder_in_word,
  input wire logic [WORD_W-1:0] serializer_word,
  input wire logic serial_out_enable,
  input wire logic channel_alarm_pin
);
  // control registers rebuilt from write frames seen on the wire
  logic c1_reg, c2_reg, ok, gbad, rep, alm;
  logic [4:0] n_reg;
  logic [23:0] sh_reg;
  logic [DATA_W-1:0] al_reg, lp_reg;
  logic [3:0] age_reg;
  always_ff @(posedge ref_clk) begin
    c1_reg <= link_clk;
    c2_reg <= c1_reg;
  end
  always_ff @(posedge ref_clk) begin
    if (srst || !link_sel) n_reg <= '0;
    else if (c1_reg && !c2_reg) begin
      n_reg <= n_reg + 5'h1;
      sh_reg <= {sh_reg[22:0], link_mosi};
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      al_reg <= RST_ALARM;
      lp_reg <= RST_LOOP;
    end else if (n_reg == 5'h18 && sh_reg[23] == OP_WRITE) begin
      if (sh_reg[22:16] == ADDR_ALARM) al_reg <= sh_reg[15:0] & MASK_ALARM;
      if (sh_reg[22:16] == ADDR_LOOP) lp_reg <= sh_reg[15:0] & MASK_LOOP;
    end
  end
  // judge only after the link is quiet, since the device applies writes a few cycles late
  always_ff @(posedge ref_clk) begin
    if (srst || link_sel) age_reg <= '0;
    else if (age_reg != 4'hF) age_reg <= age_reg + 4'h1;
  end
  assign ok = age_reg == 4'hF;
  assign gbad = !gain_loop_locked && !lp_reg[B_NEAR_SER];
  assign rep = (al_reg[B_REP_SIG] && signal_lost) || (al_reg[B_REP_SYNC] && sync_lost)
    || (al_reg[B_REP_PLL] && !pll_locked) || (lp_reg[B_REP_GAIN] && gbad)
    || (lp_reg[B_REP_CAL] && !offset_cal_complete);
  assign alm = (al_reg[B_SIG_ROUTE] && signal_lost) || (al_reg[B_SYNC_ROUTE] && sync_lost)
    || (al_reg[B_PLL_ROUTE] && !pll_locked) || (al_reg[B_BAD_ROUTE] && bad_symbol)
    || (lp_reg[B_GAIN_ROUTE] && gbad) || (lp_reg[B_CAL_ROUTE] && !offset_cal_complete);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_alarm_or: assert property (ok |=> channel_alarm_pin == $past(alm))
    else $error("alarm pin mismatch");
  a_rep_k307: assert property (ok && rep && decoder_enable |=> rx_par_word == K307_WORD)
    else $error("expected K30.7 fill");
  a_rep_zero: assert property (ok && rep && !decoder_enable |=> rx_par_word == ZERO_WORD)
    else $error("expected zero fill");
  a_pass_through: assert property (ok && !rep && lp_reg[3:0] == 4'h0
    |=> rx_par_word == $past(rx_decoded_word))
    else $error("rx data altered");
  a_near_enc: assert property (ok && !rep && lp_reg[3:0] == 4'h1
    |=> rx_par_word == $past(tx_encoded_word) && serial_out_enable)
    else $error("shallow local path wrong");
  a_near_ser: assert property (ok && !rep && lp_reg[3:0] == 4'h2
    |=> rx_par_word == $past(tx_encoded_word, 2) && !serial_out_enable)
    else $error("deep local path wrong");
  a_far_codec: assert property (ok && lp_reg[3:0] == 4'h4
    |=> encoder_in_word == $past(rx_decoded_word))
    else $error("shallow remote path wrong");
  a_far_full: assert property (ok && lp_reg[3:0] == 4'h8
    |=> encoder_in_word == $past(rx_par_word))
    else $error("deep remote path wrong");
  a_gen_off: assert property (ok && !lp_reg[B_GEN] |=> serializer_word == $past(tx_encoded_word))
    else $error("serializer not normal");
  a_reset_out: assert property ($fell(srst) |-> serial_out_enable && !channel_alarm_pin)
    else $error("bad state after reset");
endmodule // lpa_checker

/* bench/tb.sv */
`timescale 1ns/10ps
module tb import lpa_pkg::*;;
  logic ref_clk = 1'b0, srst = 1'b1, sw_write = 1'b0, sw_read = 1'b0, full_rate = 1'b0;
  logic dec_en = 1'b1, ser_en, alarm;
  logic [SWING_W-1:0] swing;
  logic [5:0] flt = '0;
  logic [ADDR_W-1:0] sw_addr = '0;
  logic [DATA_W-1:0] sw_wdata = '0, sw_rdata, q, st;
  logic [WORD_W-1:0] raw = 20'h12345, dec = 20'h0F0F1, tpar = 20'h33CC3, tenc = 20'h5A5A5;
  logic [WORD_W-1:0] rx_par, enc_in, ser_w;
  int n_errors = 0, n_checks = 0;
  lpa_link_if link ();
  lpa_host i_lpa_host (.ref_clk(ref_clk), .srst(srst), .link(link), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read), .sw_rdata(sw_rdata),
    .full_rate(full_rate));
  lpa_device i_lpa_device (.ref_clk(ref_clk), .srst(srst), .link(link), .rx_raw_word(raw),
    .rx_decoded_word(dec), .decoder_enable(dec_en), .tx_par_word(tpar), .tx_encoded_word(tenc),
    .signal_lost(flt[0]), .sync_lost(flt[1]), .pll_locked(!flt[2]), .gain_loop_locked(!flt[3]),
    .offset_cal_complete(!flt[4]), .bad_symbol(flt[5]), .rx_par_word(rx_par),
    .encoder_in_word(enc_in), .serializer_word(ser_w), .serial_out_enable(ser_en),
    .tx_swing(swing), .channel_alarm_pin(alarm));
  lpa_checker i_lpa_checker (.ref_clk(ref_clk), .srst(srst), .link_clk(link.link_clk),
    .link_sel(link.link_sel), .link_mosi(link.link_mosi), .rx_decoded_word(dec),
    .tx_encoded_word(tenc), .decoder_enable(dec_en), .signal_lost(flt[0]), .sync_lost(flt[1]),
    .pll_locked(!flt[2]), .gain_loop_locked(!flt[3]), .offset_cal_complete(!flt[4]),
    .bad_symbol(flt[5]), .rx_par_word(rx_par), .encoder_in_word(enc_in),
    .serializer_word(ser_w), .serial_out_enable(ser_en), .channel_alarm_pin(alarm));
  initial forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [WORD_W-1:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // the write strobe drops and one edge passes, so the next request never re-drives in the same step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_write <= 1'b1;
    tick(1);
    sw_write <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    sw_addr <= a;
    sw_read <= 1'b1;
    tick(1);
    sw_read <= 1'b0;
    #1 d = sw_rdata;
    tick(1);
  endtask
  task automatic acc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic op);
    int k = 0;
    wr(H_TARGET, {9'h0, a});
    wr(H_WDATA, d);
    wr(H_GO, {15'h0, op});
    tick(1);
    do begin
      rd(H_STAT, st);
      k++;
    end while (st[HS_BUSY] !== 1'b0 && k < 1000);
    if (st[HS_BUSY] !== 1'b0) begin
      n_errors++;
      $display("wrong value at %0t: link access hung", $time);
    end
  endtask
  task automatic dw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    acc(a, d, OP_WRITE);
  endtask
  task automatic dr(input logic [ADDR_W-1:0] a);
    acc(a, 16'h0000, OP_READ);
    rd(H_RDATA, q);
  endtask
  task automatic t_regs;
    dr(ADDR_LOOP);
    chk({4'h0, RST_LOOP}, {4'h0, q});
    dr(ADDR_ALARM);
    chk({4'h0, RST_ALARM}, {4'h0, q});
    dw(ADDR_LOOP, 16'hFFF0);
    dr(ADDR_LOOP);
    chk(20'h037F0, {4'h0, q});
    $display("regs done");
  endtask
  task automatic t_replace;
    dw(ADDR_ALARM, 16'h0070);
    dw(ADDR_LOOP, 16'h0730);
    for (int i = 0; i < 5; i++) begin
      for (int e = 0; e < 2; e++) begin
        flt <= 6'(1 << i);
        dec_en <= e[0];
        tick(3);
        chk(e ? K307_WORD : ZERO_WORD, rx_par);
      end
    end
    $display("replace done");
  endtask
  task automatic t_alarm;
    dw(ADDR_ALARM, 16'h0708);
    dw(ADDR_LOOP, 16'h07C0);
    for (int i = 0; i < 7; i++) begin
      flt <= 6'(1 << i);
      tick(3);
      chk(20'(i < 6), 20'(alarm));
    end
    dw(ADDR_ALARM, 16'h0000);
    dw(ADDR_LOOP, 16'h0700);
    flt <= 6'h3F;
    tick(3);
    chk(20'h0, 20'(alarm));
    chk(dec, rx_par);
    chk(tpar, enc_in);
    $display("alarm done");
  endtask
  task automatic t_loop;
    acc(ADDR_LOOP, 16'h0702, OP_WRITE);
    chk(20'h1, 20'(st[HS_REFUSED]));
    flt <= 6'h08;
    dw(ADDR_SWING, 16'h0005);
    dr(ADDR_STATUS);
    chk(20'h1, 20'(q[ST_CAL]));
    dw(ADDR_LOOP, 16'h07A2);
    tick(4);
    chk(tenc, rx_par);
    chk(20'h0, {18'h0, ser_en, alarm});
    chk(20'h0, 20'(swing));
    dw(ADDR_LOOP, 16'h0701);
    tick(3);
    chk({tenc[19:1], 1'b1}, {rx_par[19:1], ser_en});
    dw(ADDR_LOOP, 16'h0704);
    chk(dec, enc_in);
    dw(ADDR_LOOP, 16'h0708);
    chk(dec, enc_in);
    chk(dec, rx_par);
    $display("loop done");
  endtask
  task automatic t_pattern;
    logic [WORD_W-1:0] w;
    flt <= '0;
    for (int c = 3; c < 8; c++) begin
      dw(ADDR_LOOP, {5'h04, 3'(c), 8'h00});
      chk(20'h1, 20'(ser_w != tenc));
      w = ser_w;
      tick(c == 3 ? 4 : 2);
      if (c < 5) chk(w, ser_w);
    end
    dw(ADDR_LOOP, 16'h1500);
    chk(tenc, ser_w);
    dr(ADDR_STATUS);
    chk(20'h1, 20'(q[ST_CHK_ERR]));
    full_rate <= 1'b1;
    acc(ADDR_LOOP, 16'h2300, OP_WRITE);
    chk(20'h1, 20'(st[HS_REFUSED]));
    full_rate <= 1'b0;
    $display("pattern done");
  endtask
  initial begin
    tick(5);
    srst <= 1'b0;
    tick(1);
    t_regs;
    t_replace;
    t_alarm;
    t_loop;
    t_pattern;
    print_verdict;
  end
  initial begin
    tick(90000);
    n_errors++;
    print_verdict;
  end
endmodule // tb
